// ===== logic/ext_bus_defs.vh
// Constants shared by the external bus strobe, wait and hold logic.
`ifndef EXT_BUS_DEFS_VH
`define EXT_BUS_DEFS_VH
`define AREA_EXTERNAL 2'h0
`define AREA_SPECIAL  2'h1
`define AREA_INTERNAL 2'h2
`define MODE_SINGLE   2'h0
`define MODE_EXPAND   2'h1
`define MODE_MICRO    2'h2
`define SCHEME_RESET  1'h0
`define WAIT_CLKS_SEP 2'h2
`define WAIT_CLKS_MUX 2'h3
`define SPECIAL_CLKS  2'h2
`define ADDR_RESET    20'h00000
`define WATCHDOG_RUN  1'h1
`endif

// ===== logic/bus_grant_arbiter.v
// Fixed priority bus ownership arbiter for hold, transfer engine and CPU.
`timescale 1ns/1ns
module bus_grant_arbiter (
  input  wire holdReq,
  input  wire engineReq,
  input  wire cpuReq,
  output reg  grantHold,
  output reg  grantEngine,
  output reg  grantCpu
);
  // Hold beats the transfer engine, which beats the CPU.
  always @* begin
    grantHold   = holdReq;
    grantEngine = ~holdReq & engineReq;
    grantCpu    = ~holdReq & ~engineReq & cpuReq;
  end
endmodule

// ===== logic/external_bus_strobe_wait_hold.v
// External bus cycle sequencer: strobes, address latch, wait and hold.
`timescale 1ns/1ns
`include "ext_bus_defs.vh"
// Functional notes
// - Scheme bit picks single or split write strobes on a wide bus
// - Reset selects single write strobe scheme
// - Split scheme: lane strobes pick bytes
// - Single scheme: upper enable and A0 pick
// - Narrow bus moves one byte, enable meaningless
// - Multiplexed pins carry address, shift when wide
// - Wait pin sampled each falling bus edge
// - Wait honoured only in zero-wait-bit areas
// - Outputs frozen during wait state
// - Wait ignored while software wait clocks remain
// - Hold after current access, ack follows request
// - Priority hold, transfer engine, then CPU
// - Hold floats bus and low ports
// - Watchdog stops while bus held
// - Special area drives address, strobes, no selects
// - Internal area keeps address, strobes high
// - Bus signals only in expansion modes
// - Width pin high means 8-bit bus
// - Area wait bit one gives one clock when soft wait bit clear
module external_bus_strobe_wait_hold #(
  parameter ADDR_W = 20,
  parameter DATA_W = 16
) (
  input  wire              core_clk,
  input  wire              rst_n,
  input  wire [1:0]        procMode,        // Processor mode select.
  input  wire              splitScheme,     // Strobe scheme select bit.
  input  wire [3:0]        areaWaitBits,    // Per-area one-clock bits.
  input  wire              softWaitAll,     // Global software wait bit.
  input  wire              muxBus,          // Multiplexed address/data.
  input  wire              byteWidthPin,    // High selects 8-bit bus.
  input  wire              readyPin_n,      // External wait request.
  input  wire              busClkFall,      // Bus clock falling edge.
  input  wire              holdPin_n,       // External bus request.
  input  wire              cpuReq,          // CPU access request.
  input  wire              engineReq,       // Transfer engine request.
  input  wire              reqWrite,        // Access is a write.
  input  wire [1:0]        reqArea,         // External, special, internal.
  input  wire [1:0]        reqArea_cs,      // Chip-select area index.
  input  wire [1:0]        reqLanes,        // Bit 0 even, bit 1 odd byte.
  input  wire [ADDR_W-1:0] reqAddr,
  input  wire [DATA_W-1:0] reqWdata,
  input  wire [DATA_W-1:0] dataIn,          // Data pin levels.
  output reg  [ADDR_W-1:0] addrOut,
  output reg               addrOe,
  output reg  [DATA_W-1:0] dataOut,
  output reg               dataOe,
  output reg  [3:0]        chipSel_n,
  output reg               chipSelOe,
  output reg               read_n,
  output reg               write_n,         // Single write strobe.
  output reg               low_lane_store_n,
  output reg               high_lane_store_n,
  output reg               upper_lane_enable_n,
  output reg               strobeOe,
  output reg               addrLatch,
  output reg               bus_grant_ack_n,
  output reg               lowPortsFloat,   // Ports 0 to 5 released.
  output reg               watchdogRun,
  output reg               accessDone,      // One-cycle completion pulse.
  output reg               engineGranted,
  output reg  [DATA_W-1:0] readData
);
  localparam IDLE = 2'h0;
  localparam ADDR = 2'h1;
  localparam DATA = 2'h2;
  localparam HOLD = 2'h3;

  reg [1:0]  state_reg;       // Sequencer state.
  reg [1:0]  state_next;
  reg [1:0]  cnt_reg;         // Remaining bus clocks of the access.
  reg [1:0]  cnt_next;
  reg        wr_reg;          // Latched direction of current access.
  reg [1:0]  area_reg;        // Latched area of current access.
  reg        rdyOk_reg;       // Wait pin honoured for this access.
  reg [2:0]  rdySync_reg;     // Three-stage pin synchroniser.
  reg [2:0]  holdSync_reg;
  reg        rdyLow_reg;      // Filtered wait pin level.
  reg        holdLow_reg;     // Filtered request level.
  reg        scheme_reg;      // Scheme in effect, cleared by reset.

  wire expandMode = (procMode == `MODE_EXPAND) |
                    (procMode == `MODE_MICRO);
  wire narrow     = byteWidthPin;
  wire grantHold;
  wire grantEngine;
  wire grantCpu;

  // Fixed-priority selection among the three bus users.
  bus_grant_arbiter u_arb (
    .holdReq     (holdLow_reg & expandMode),
    .engineReq   (engineReq),
    .cpuReq      (cpuReq),
    .grantHold   (grantHold),
    .grantEngine (grantEngine),
    .grantCpu    (grantCpu)
  );

  // Bus clocks an access takes; the special area is fixed at two.
  function [1:0] cycleClks;
    input [1:0] area;
    input       oneClk;
    begin
      if (area == `AREA_SPECIAL)
        cycleClks = `SPECIAL_CLKS;
      else if (area == `AREA_EXTERNAL & oneClk & ~softWaitAll)
        cycleClks = 2'h1;
      else if (area == `AREA_EXTERNAL & muxBus)
        cycleClks = `WAIT_CLKS_MUX;
      else if (area == `AREA_EXTERNAL | softWaitAll)
        cycleClks = `WAIT_CLKS_SEP;
      else
        cycleClks = 2'h1;
    end
  endfunction

  // Pin synchronisers; a change counts once stages two and three agree.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      rdySync_reg  <= 3'h7;
      holdSync_reg <= 3'h7;
      rdyLow_reg   <= 1'h0;
      holdLow_reg  <= 1'h0;
    end else begin
      rdySync_reg  <= {rdySync_reg[1:0], readyPin_n};
      holdSync_reg <= {holdSync_reg[1:0], holdPin_n};
      if (rdySync_reg[1] == rdySync_reg[2])
        rdyLow_reg <= ~rdySync_reg[2];
      if (holdSync_reg[1] == holdSync_reg[2])
        holdLow_reg <= ~holdSync_reg[2];
    end
  end

  wire startReq = (grantEngine | grantCpu) & expandMode;

  // Wait state: pin sampled on falling bus edges, only when honoured.
  // Ready is not taken while software clocks remain, so it can only
  // stretch the final clock of an access.
  wire rdyTake = busClkFall & rdyOk_reg & (state_reg == DATA) &
                 (cnt_reg <= 2'h1);
  // The level seen at this fall decides at once; a registered copy would
  // act one fall late and let the first wait slip through.
  wire stallNow = rdyTake & rdyLow_reg;

  // Next-state logic of the access sequencer.
  always @* begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      IDLE: begin
        if (grantHold)
          state_next = HOLD;
        else if (startReq) begin
          state_next = ADDR;
          cnt_next   = cycleClks(reqArea, areaWaitBits[reqArea_cs]);
        end
      end
      ADDR: begin
        if (busClkFall)
          state_next = DATA;
      end
      DATA: begin
        // A wait stretches the cycle; the final count is held.
        if (busClkFall & ~stallNow) begin
          if (cnt_reg <= 2'h1)
            state_next = IDLE;
          else
            cnt_next = cnt_reg - 2'h1;
        end
      end
      HOLD: begin
        if (!holdLow_reg)
          state_next = IDLE;
      end
      default: state_next = IDLE;
    endcase
  end

  wire lanesWide = ~narrow;

  // Sequencer registers and all pin-facing outputs.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      state_reg           <= IDLE;
      cnt_reg             <= 2'h0;
      wr_reg              <= 1'h0;
      area_reg            <= `AREA_INTERNAL;
      rdyOk_reg           <= 1'h0;
      scheme_reg          <= `SCHEME_RESET;
      addrOut             <= `ADDR_RESET;
      addrOe              <= 1'h0;
      dataOut             <= {DATA_W{1'b0}};
      dataOe              <= 1'h0;
      chipSel_n           <= 4'hf;
      chipSelOe           <= 1'h0;
      read_n              <= 1'h1;
      write_n             <= 1'h1;
      low_lane_store_n    <= 1'h1;
      high_lane_store_n   <= 1'h1;
      upper_lane_enable_n <= 1'h1;
      strobeOe            <= 1'h0;
      addrLatch           <= 1'h0;
      bus_grant_ack_n     <= 1'h1;
      lowPortsFloat       <= 1'h0;
      watchdogRun         <= `WATCHDOG_RUN;
      accessDone          <= 1'h0;
      engineGranted       <= 1'h0;
      readData            <= {DATA_W{1'b0}};
    end else begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      accessDone <= 1'h0;
      // Scheme bit is honoured only on a wide bus; narrow forces single.
      scheme_reg <= splitScheme & lanesWide;
      case (state_reg)
        IDLE: begin
          strobeOe  <= expandMode;
          addrOe    <= expandMode;
          chipSelOe <= expandMode;
          if (grantHold) begin
            bus_grant_ack_n <= 1'h0;
            addrOe          <= 1'h0;
            dataOe          <= 1'h0;
            chipSelOe       <= 1'h0;
            strobeOe        <= 1'h0;
            lowPortsFloat   <= 1'h1;
            watchdogRun     <= 1'h0;
          end else if (startReq) begin
            engineGranted <= grantEngine;
            wr_reg        <= reqWrite;
            area_reg      <= reqArea;
            rdyOk_reg     <= (reqArea == `AREA_EXTERNAL) &
                             ~areaWaitBits[reqArea_cs];
            if (reqArea != `AREA_INTERNAL) begin
              // External and special accesses put out the address.
              if (muxBus & reqArea == `AREA_EXTERNAL) begin
                addrLatch <= 1'h1;
                dataOe    <= 1'h1;
                if (narrow)
                  dataOut <= {{(DATA_W-8){1'b0}}, reqAddr[7:0]};
                else
                  dataOut <= {{(DATA_W-8){1'b0}}, reqAddr[8:1]};
              end
              addrOut <= reqAddr;
              if (!narrow)
                upper_lane_enable_n <= ~reqLanes[1];
              else
                upper_lane_enable_n <= 1'h1;
            end
            // Selects go low for external areas only.
            chipSel_n <= 4'hf;
            if (reqArea == `AREA_EXTERNAL)
              chipSel_n[reqArea_cs] <= 1'h0;
          end
        end
        ADDR: begin
          addrLatch <= 1'h0;
          if (busClkFall & area_reg != `AREA_INTERNAL) begin
            // Strobes open; internal area keeps them high.
            dataOe  <= wr_reg;
            dataOut <= reqWdata;
            read_n  <= wr_reg;
            if (wr_reg & scheme_reg) begin
              low_lane_store_n  <= ~reqLanes[0];
              high_lane_store_n <= ~reqLanes[1];
            end else if (wr_reg)
              write_n <= 1'h0;
          end
        end
        DATA: begin
          // During a wait every output is left as it stands.
          if (busClkFall & ~stallNow & cnt_reg <= 2'h1) begin
            read_n            <= 1'h1;
            write_n           <= 1'h1;
            low_lane_store_n  <= 1'h1;
            high_lane_store_n <= 1'h1;
            chipSel_n         <= 4'hf;
            dataOe            <= 1'h0;
            accessDone        <= 1'h1;
            if (!wr_reg)
              readData <= dataIn;
          end
        end
        HOLD: begin
          if (!holdLow_reg) begin
            bus_grant_ack_n <= 1'h1;
            lowPortsFloat   <= 1'h0;
            watchdogRun     <= 1'h1;
            addrOe          <= expandMode;
            chipSelOe       <= expandMode;
            strobeOe        <= expandMode;
          end
        end
        default: begin
          bus_grant_ack_n <= 1'h1;
        end
      endcase
    end
  end
endmodule

// ===== testbench/ext_bus_checker_assertions.sv
// Property checker for the external bus strobe, wait and hold sequencer.
`timescale 1ns/1ns
`include "ext_bus_defs.vh"
module ext_bus_checker (
  input wire        core_clk,
  input wire        rst_n,
  input wire [1:0]  procMode,
  input wire [1:0]  reqArea,
  input wire        splitScheme,
  input wire        holdPin_n,
  input wire        busClkFall,
  input wire [19:0] addrOut,
  input wire [3:0]  chipSel_n,
  input wire        read_n,
  input wire        write_n,
  input wire        low_lane_store_n,
  input wire        high_lane_store_n,
  input wire        addrLatch,
  input wire        addrOe,
  input wire        dataOe,
  input wire        strobeOe,
  input wire        bus_grant_ack_n,
  input wire        lowPortsFloat,
  input wire        watchdogRun
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  // A strobe low now, and one that has stayed low for a second cycle.
  sequence s_strobe;
    !(read_n && write_n);
  endsequence
  sequence s_strobe_held;
    s_strobe ##1 s_strobe;
  endsequence
  a_hold_floats: assert property (
    !bus_grant_ack_n |-> lowPortsFloat && !addrOe && !dataOe && !strobeOe)
    else $error("bus driven in hold");
  a_hold_dog: assert property (!bus_grant_ack_n |-> !watchdogRun)
    else $error("watchdog runs in hold");
  a_ack_release: assert property (holdPin_n[*6] |-> bus_grant_ack_n)
    else $error("ack stays low after release");
  a_wait_freeze: assert property (
    s_strobe_held |-> $stable(addrOut) && $stable(chipSel_n))
    else $error("address moved under strobe");
  a_strobe_edge: assert property (
    $fell(read_n) || $fell(write_n) |-> $past(busClkFall))
    else $error("strobe off bus clock");
  a_read_only: assert property (
    splitScheme && !read_n |-> write_n && low_lane_store_n && high_lane_store_n)
    else $error("write strobe during read");
  a_ale_quiet: assert property (s_strobe |-> !addrLatch)
    else $error("latch strobe during data");
  a_internal_quiet: assert property (
    reqArea == `AREA_INTERNAL |-> read_n && write_n)
    else $error("strobe on internal access");
  a_special_nocs: assert property (
    reqArea == `AREA_SPECIAL && !(read_n && write_n) |-> &chipSel_n)
    else $error("select on special access");
  a_single_quiet: assert property (
    procMode == `MODE_SINGLE |-> read_n && write_n && !addrLatch)
    else $error("bus active in single chip");
  a_read_bounded: assert property ($fell(read_n) |-> ##[1:400] read_n)
    else $error("read strobe never ends");
endmodule
bind external_bus_strobe_wait_hold ext_bus_checker i_chk (.*);

// ===== testbench/ext_bus_partner.sv
// Model of the memories and peripherals on the far side of the bus.
`timescale 1ns/1ns
module ext_bus_partner (
  input  wire         core_clk,
  input  wire         busClkFall,
  input  wire         byteWidthPin,
  input  wire         splitScheme,
  input  wire  [19:0] addrOut,
  input  wire  [15:0] dataOut,
  input  wire         read_n,
  input  wire         write_n,
  input  wire         low_lane_store_n,
  input  wire         high_lane_store_n,
  input  wire         upper_lane_enable_n,
  input  wire         addrLatch,
  input  wire  [2:0]  waitFalls,
  output logic [15:0] dataIn,
  output logic        readyPin_n,
  output logic [15:0] lastWr,
  output logic [1:0]  lastLanes,
  output logic [19:0] latchedAddr
);
  logic [2:0] waitLeft = 3'h0;  // Bus clocks still to stretch.
  logic       strobeQ = 1'b0;
  wire        strobe = !(read_n && write_n);
  assign readyPin_n = (waitLeft == 3'h0);
  // A slow device holds the wait line low for waitFalls bus clocks.
  always @(posedge core_clk) begin
    strobeQ <= strobe;
    if (strobe && !strobeQ)
      waitLeft <= waitFalls;
    else if (busClkFall && waitLeft != 3'h0)
      waitLeft <= waitLeft - 3'h1;
    // Released pins show a changing pattern, never stale data.
    dataIn <= read_n ? ~dataIn : addrOut[15:0] ^ 16'h5a3c;
    if (addrLatch)
      latchedAddr <= byteWidthPin ? {addrOut[19:8], dataOut[7:0]}
                                  : {addrOut[19:9], dataOut[7:0], addrOut[0]};
    if (!(write_n && low_lane_store_n && high_lane_store_n)) begin
      lastWr <= dataOut;
      lastLanes <= splitScheme ? {!high_lane_store_n, !low_lane_store_n}
                               : {!upper_lane_enable_n, !addrOut[0]};
    end
  end
endmodule

// ===== testbench/external_bus_strobe_wait_hold_bench.sv
// Self-checking bench for the external bus strobe, wait and hold logic.
`timescale 1ns/1ns
`include "ext_bus_defs.vh"
module external_bus_strobe_wait_hold_bench;
  logic core_clk, rst_n, splitScheme, softWaitAll, muxBus, byteWidthPin;
  logic readyPin_n, busClkFall, holdPin_n, cpuReq, engineReq, reqWrite;
  logic addrOe, dataOe, chipSelOe, read_n, write_n, low_lane_store_n;
  logic high_lane_store_n, strobeOe, upper_lane_enable_n, addrLatch;
  logic bus_grant_ack_n, lowPortsFloat, watchdogRun, accessDone, engineGranted;
  logic [1:0]  procMode, reqArea, reqArea_cs, reqLanes, lastLanes, bcnt;
  logic [2:0]  waitFalls;
  logic [3:0]  areaWaitBits, chipSel_n;
  logic [15:0] reqWdata, dataIn, dataOut, readData, lastWr, mask;
  logic [19:0] reqAddr, addrOut, latchedAddr, want, seen;
  logic [19:0] expQ[$];  // Skip flag, write flag, lanes, data.
  int miscompares, check_count, lastN, slowN;
  external_bus_strobe_wait_hold i_dut (.*);
  ext_bus_partner i_mem (.*);
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // One bus clock falling edge every fourth core clock.
  always @(negedge core_clk) begin
    if (!rst_n) begin
      bcnt <= 2'h0;
      busClkFall <= 1'b0;
    end else begin
      bcnt <= bcnt + 2'h1;
      busClkFall <= (bcnt == 2'h3);
    end
  end
  task automatic chk(input string what, input logic [19:0] exp, act);
    check_count++;
    if (act !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, act);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // One access; requests stay put until the completion pulse is seen.
  task automatic acc(input logic wr, input logic [1:0] ar, ln, input logic e);
    int n;
    logic saw;
    saw = 1'b0;
    // Let one edge pass so the previous request is seen low first.
    @(negedge core_clk);
    procMode = 2'($urandom_range(2, 1));
    {reqWrite, reqArea, reqLanes, reqArea_cs} = {wr, ar, ln, 2'($urandom)};
    reqWdata = 16'($urandom);
    reqAddr = {20'($urandom) & 20'hffffe} | {19'h0, ln == 2'b10};
    expQ.push_back({ar != `AREA_EXTERNAL && !(wr && ar == `AREA_SPECIAL), wr,
                    ln, wr ? reqWdata : reqAddr[15:0] ^ 16'h5a3c});
    {engineReq, cpuReq} = {e, 1'b1};
    for (n = 0; n < 300 && accessDone !== 1'b1; n++) begin
      @(negedge core_clk);
      saw |= (engineGranted === 1'b1);
    end
    {engineReq, cpuReq, lastN} = {2'b00, n};
    chk("engine grant", {19'h0, e}, {19'h0, saw});
    if (n == 300) begin
      $display("[ERR] access done expected 1 seen 0");
      miscompares++;
      tally_and_finish();
    end
  endtask
  // Pairs each completion with the oldest expectation.
  always @(negedge core_clk) begin
    if (accessDone === 1'b1 && expQ.size() == 0)
      chk("spurious done", 20'h0, 20'h1);
    else if (accessDone === 1'b1) begin
      want = expQ.pop_front();
      mask = {{8{want[17]}}, {8{want[16]}}};
      seen = want[18] ? {2'b01, lastLanes, lastWr & mask}
                      : {want[19:16], readData & mask};
      if (!want[19]) chk("transfer", want & {4'hf, mask}, seen);
    end
  end
  initial begin
    int n;
    void'($urandom(71256));
    {rst_n, splitScheme, softWaitAll, muxBus, byteWidthPin, holdPin_n} = 6'h1;
    {cpuReq, engineReq, reqWrite, procMode} = 5'h01;
    {reqArea, reqArea_cs, reqLanes, areaWaitBits, waitFalls} = 13'h1;
    {reqAddr, reqWdata, miscompares, check_count} = 0;
    repeat (5) @(negedge core_clk);
    rst_n = 1'b1;
    @(negedge core_clk);
    for (n = 1; n < 4; n++) acc(1'b1, `AREA_EXTERNAL, 2'(n), 1'b0);
    acc(1'b0, `AREA_EXTERNAL, 2'b11, 1'b0);
    $display("test single scheme done");
    splitScheme = 1'b1;
    for (n = 1; n < 4; n++) acc(1'b1, `AREA_EXTERNAL, 2'(n), 1'b0);
    acc(1'b0, `AREA_EXTERNAL, 2'b01, 1'b0);
    slowN = lastN;
    waitFalls = 3'h3;
    acc(1'b0, `AREA_EXTERNAL, 2'b11, 1'b0);
    chk("ready stretch", 20'h1, {19'h0, lastN > slowN + 4});
    slowN = lastN;
    areaWaitBits = 4'hf;
    acc(1'b1, `AREA_EXTERNAL, 2'b11, 1'b0);
    chk("wait stretch", 20'h1, {19'h0, slowN > lastN});
    slowN = lastN;
    softWaitAll = 1'b1;
    acc(1'b1, `AREA_EXTERNAL, 2'b11, 1'b0);
    chk("soft wait", 20'h1, {19'h0, lastN > slowN});
    $display("test scheme and wait done");
    {areaWaitBits, softWaitAll, splitScheme, byteWidthPin, muxBus} = 8'h03;
    acc(1'b0, `AREA_EXTERNAL, 2'b01, 1'b0);
    chk("latched address", reqAddr, latchedAddr);
    byteWidthPin = 1'b0;
    acc(1'b0, `AREA_EXTERNAL, 2'b11, 1'b0);
    chk("latched address", reqAddr, latchedAddr);
    muxBus = 1'b0;
    acc(1'b1, `AREA_SPECIAL, 2'b11, 1'b0);
    acc(1'b0, `AREA_SPECIAL, 2'b11, 1'b0);
    acc(1'b0, `AREA_INTERNAL, 2'b11, 1'b0);
    acc(1'b1, `AREA_EXTERNAL, 2'b11, 1'b1);
    $display("test bus forms done");
    fork
      acc(1'b0, `AREA_EXTERNAL, 2'b11, 1'b0);
      begin
        repeat (6) @(negedge core_clk);
        holdPin_n = 1'b0;
        for (n = 0; n < 99 && bus_grant_ack_n !== 1'b0; n++) @(negedge core_clk);
        chk("hold after access", 20'h0, 20'(expQ.size()));
        chk("hold state", 20'h2, {18'h0, lowPortsFloat, watchdogRun});
        holdPin_n = 1'b1;
        for (n = 0; n < 99 && bus_grant_ack_n !== 1'b1; n++) @(negedge core_clk);
        chk("ack released", 20'h1, {19'h0, bus_grant_ack_n});
      end
    join
    {procMode, cpuReq} = {`MODE_SINGLE, 1'b1};
    lastN = 0;
    repeat (40) begin
      @(negedge core_clk);
      lastN += (accessDone === 1'b1);
    end
    cpuReq = 1'b0;
    chk("single chip", 20'h0, 20'(lastN));
    chk("single drive", 20'h0, {17'h0, strobeOe, addrOe, chipSelOe});
    $display("test hold and single chip done");
    tally_and_finish();
  end
endmodule
